/* File: hdl/dmsp_top.sv */
// Dual mode serial port: UART and 3-wire clocked serial with register port.
//
// Design decision made here: strobed register access.
`default_nettype none
module dmsp_top (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rd_data_o,
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_o,
  input wire logic serial_in_pin_i,
  output logic serial_out_pin_o,
  output logic rx_complete_irq_o,
  output logic tx_complete_irq_o,
  output logic clocked_xfer_done_irq_o
);
  logic [7:0] async_mode_control;
  logic [7:0] clocked_mode_control;
  logic [7:0] baud_source_select;
  logic [7:0] tx_shift_reg;
  logic [7:0] rx_buffer;
  logic rx_full;
  logic parity_err;
  logic framing_err;
  logic overrun_err;
  logic tick;
  logic sck_meta, sck_s, sck_prev;
  logic si_meta, si_s;
  logic tx_enable, rx_enable, clocked_mode_enable, first_bit_select, clock_source_select;
  logic char_length_sel, stop_length_sel;
  dmsp_pkg::dmsp_parity_t parity_sel;
  logic wr_async, wr_clocked, wr_baud, wr_tx, rd_rx;
  dmsp_pkg::dmsp_state_t tx_state, rx_state;
  logic [2:0] tx_sub, rx_sub;
  logic [3:0] tx_cnt, rx_cnt;
  logic [7:0] tx_data, rx_sh;
  logic tx_line, tx_second_stop;
  logic rx_par_bad, rx_pend, rx_load;
  logic csi_busy, csi_out, csi_done;
  logic [7:0] csi_sh;
  logic [3:0] csi_cnt;
  logic fall_ev, rise_ev;
  logic int_rise_d;
  logic [3:0] char_bits;

  assign tx_enable = async_mode_control[dmsp_pkg::TXE_BIT];
  assign rx_enable = async_mode_control[dmsp_pkg::RXE_BIT];
  assign parity_sel = dmsp_pkg::dmsp_parity_t'({async_mode_control[dmsp_pkg::PS_HI_BIT],
                                                async_mode_control[dmsp_pkg::PS_LO_BIT]});
  assign char_length_sel = async_mode_control[dmsp_pkg::CL_BIT];
  assign stop_length_sel = async_mode_control[dmsp_pkg::SL_BIT];
  assign clocked_mode_enable = clocked_mode_control[dmsp_pkg::CSIE_BIT];
  assign first_bit_select = clocked_mode_control[dmsp_pkg::DIR_BIT];
  assign clock_source_select = clocked_mode_control[dmsp_pkg::CSCK_BIT];
  assign char_bits = char_length_sel ? dmsp_pkg::BITS_8 : dmsp_pkg::BITS_7;
  assign wr_async = wr_i && (addr_i == dmsp_pkg::ADDR_ASYNC);
  assign wr_clocked = wr_i && (addr_i == dmsp_pkg::ADDR_CLOCKED);
  assign wr_baud = wr_i && (addr_i == dmsp_pkg::ADDR_BAUD);
  assign wr_tx = wr_i && (addr_i == dmsp_pkg::ADDR_TXSHIFT);
  assign rd_rx = rd_i && (addr_i == dmsp_pkg::ADDR_RXBUF);

  // Parity over the valid character bits; the zero-parity mode sends zero.
  function automatic logic parity_of(input logic [7:0] d, input logic cl, input dmsp_pkg::dmsp_parity_t ps);
    logic p;
    p = cl ? ^d : ^d[6:0];
    case (ps)
      dmsp_pkg::DMSP_PAR_ODD: parity_of = ~p;
      dmsp_pkg::DMSP_PAR_EVEN: parity_of = p;
      default: parity_of = 1'b0;
    endcase
  endfunction : parity_of

  dmsp_baud_gen u_baud (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .div_code_i(baud_source_select[7:4]),
    .tick_o(tick)
  );

  // Pin synchronisers; only the second stage and the sck_prev edge copy feed logic.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sck_meta <= 1'b1;
      sck_s <= 1'b1;
      sck_prev <= 1'b1;
      si_meta <= 1'b1;
      si_s <= 1'b1;
    end else begin
      sck_meta <= serial_clock_pin_i;
      sck_s <= sck_meta;
      sck_prev <= sck_s;
      si_meta <= serial_in_pin_i;
      si_s <= si_meta;
    end
  end

  // Control registers keep only their defined bits.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      async_mode_control <= dmsp_pkg::RESET_VAL;
      clocked_mode_control <= dmsp_pkg::RESET_VAL;
      baud_source_select <= dmsp_pkg::RESET_VAL;
    end else begin
      if (wr_async) begin
        async_mode_control <= wr_data_i & dmsp_pkg::ASYNC_MASK;
      end
      if (wr_clocked) begin
        clocked_mode_control <= wr_data_i & dmsp_pkg::CLOCKED_MASK;
      end
      if (wr_baud) begin
        baud_source_select <= wr_data_i & dmsp_pkg::BAUD_MASK;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_shift_reg <= dmsp_pkg::RESET_VAL;
    end else if (wr_tx) begin
      tx_shift_reg <= wr_data_i;
    end
  end

  // UART transmitter; clearing the transmit enable aborts the frame at once.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_state <= dmsp_pkg::DMSP_IDLE;
      tx_sub <= 3'h0;
      tx_cnt <= 4'h0;
      tx_data <= 8'h00;
      tx_line <= 1'b1;
      tx_second_stop <= 1'b0;
      tx_complete_irq_o <= 1'b0;
    end else begin
      tx_complete_irq_o <= 1'b0;
      if (!tx_enable || clocked_mode_enable) begin
        tx_state <= dmsp_pkg::DMSP_IDLE;
        tx_line <= 1'b1;
      end else begin
        case (tx_state)
          dmsp_pkg::DMSP_IDLE: begin
            if (wr_tx) begin
              tx_data <= wr_data_i;
              tx_state <= dmsp_pkg::DMSP_START;
              tx_sub <= 3'h0;
              tx_line <= 1'b0;
            end
          end
          dmsp_pkg::DMSP_START: begin
            if (tick) begin
              tx_sub <= tx_sub + 3'h1;
              if (tx_sub == dmsp_pkg::SUB_LAST) begin
                tx_state <= dmsp_pkg::DMSP_DATA;
                tx_cnt <= 4'h0;
                tx_line <= tx_data[0];
              end
            end
          end
          dmsp_pkg::DMSP_DATA: begin
            if (tick) begin
              tx_sub <= tx_sub + 3'h1;
              if (tx_sub == dmsp_pkg::SUB_LAST) begin
                tx_cnt <= tx_cnt + 4'h1;
                if (tx_cnt + 4'h1 == char_bits) begin
                  if (parity_sel == dmsp_pkg::DMSP_PAR_NONE) begin
                    tx_state <= dmsp_pkg::DMSP_STOP;
                    tx_line <= 1'b1;
                    tx_second_stop <= stop_length_sel;
                  end else begin
                    tx_state <= dmsp_pkg::DMSP_PARITY;
                    tx_line <= parity_of(tx_data, char_length_sel, parity_sel);
                  end
                end else begin
                  tx_line <= tx_data[tx_cnt[2:0] + 3'h1];
                end
              end
            end
          end
          dmsp_pkg::DMSP_PARITY: begin
            if (tick) begin
              tx_sub <= tx_sub + 3'h1;
              if (tx_sub == dmsp_pkg::SUB_LAST) begin
                tx_state <= dmsp_pkg::DMSP_STOP;
                tx_line <= 1'b1;
                tx_second_stop <= stop_length_sel;
              end
            end
          end
          dmsp_pkg::DMSP_STOP: begin
            if (tick) begin
              tx_sub <= tx_sub + 3'h1;
              if (tx_sub == dmsp_pkg::SUB_LAST) begin
                if (tx_second_stop) begin
                  tx_second_stop <= 1'b0;
                end else begin
                  tx_state <= dmsp_pkg::DMSP_IDLE;
                  tx_complete_irq_o <= 1'b1;
                end
              end
            end
          end
          default: tx_state <= dmsp_pkg::DMSP_IDLE;
        endcase
      end
    end
  end

  // UART receiver; the buffer loads at the stop sample and the completion
  // pulse follows one source tick later, and a disable before that tick drops the pulse.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_state <= dmsp_pkg::DMSP_IDLE;
      rx_sub <= 3'h0;
      rx_cnt <= 4'h0;
      rx_sh <= 8'h00;
      rx_par_bad <= 1'b0;
      rx_load <= 1'b0;
      rx_pend <= 1'b0;
      rx_complete_irq_o <= 1'b0;
    end else begin
      rx_load <= 1'b0;
      rx_complete_irq_o <= 1'b0;
      if (!rx_enable || clocked_mode_enable) begin
        rx_state <= dmsp_pkg::DMSP_IDLE;
        rx_pend <= 1'b0;
      end else begin
        if (rx_pend && tick) begin
          rx_pend <= 1'b0;
          rx_complete_irq_o <= 1'b1;
        end
        case (rx_state)
          dmsp_pkg::DMSP_IDLE: begin
            if (!si_s) begin
              rx_state <= dmsp_pkg::DMSP_START;
              rx_sub <= 3'h0;
            end
          end
          dmsp_pkg::DMSP_START: begin
            if (tick) begin
              rx_sub <= rx_sub + 3'h1;
              if (rx_sub == dmsp_pkg::SUB_HALF) begin
                rx_sub <= 3'h0;
                rx_cnt <= 4'h0;
                rx_par_bad <= 1'b0;
                rx_state <= si_s ? dmsp_pkg::DMSP_IDLE : dmsp_pkg::DMSP_DATA;
              end
            end
          end
          dmsp_pkg::DMSP_DATA: begin
            if (tick) begin
              rx_sub <= rx_sub + 3'h1;
              if (rx_sub == dmsp_pkg::SUB_LAST) begin
                rx_sh <= {si_s, rx_sh[7:1]};
                rx_cnt <= rx_cnt + 4'h1;
                if (rx_cnt + 4'h1 == char_bits) begin
                  rx_state <= (parity_sel == dmsp_pkg::DMSP_PAR_NONE) ? dmsp_pkg::DMSP_STOP
                                                                      : dmsp_pkg::DMSP_PARITY;
                end
              end
            end
          end
          dmsp_pkg::DMSP_PARITY: begin
            if (tick) begin
              rx_sub <= rx_sub + 3'h1;
              if (rx_sub == dmsp_pkg::SUB_LAST) begin
                rx_state <= dmsp_pkg::DMSP_STOP;
                rx_par_bad <= (parity_sel != dmsp_pkg::DMSP_PAR_ZERO) &&
                  (si_s != parity_of(char_length_sel ? rx_sh : {1'b0, rx_sh[7:1]}, char_length_sel, parity_sel));
              end
            end
          end
          dmsp_pkg::DMSP_STOP: begin
            if (tick) begin
              rx_sub <= rx_sub + 3'h1;
              if (rx_sub == dmsp_pkg::SUB_LAST) begin
                rx_state <= dmsp_pkg::DMSP_IDLE;
                rx_load <= 1'b1;
                rx_pend <= 1'b1;
              end
            end
          end
          default: rx_state <= dmsp_pkg::DMSP_IDLE;
        endcase
      end
    end
  end

  // Internal rises act one cycle late, since data launched at a fall needs two cycles through the input synchroniser.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      int_rise_d <= 1'b0;
    end else begin
      int_rise_d <= csi_busy && clock_source_select && tick && !serial_clock_pin_o;
    end
  end

  // Clocked-mode edges: internal clock toggles per tick, external is sampled.
  assign fall_ev = clock_source_select ? (csi_busy && tick && serial_clock_pin_o)
                                       : (csi_busy && sck_prev && !sck_s);
  assign rise_ev = clock_source_select ? (csi_busy && int_rise_d)
                                       : (csi_busy && !sck_prev && sck_s);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      csi_busy <= 1'b0;
      csi_sh <= 8'h00;
      csi_cnt <= 4'h0;
      csi_out <= 1'b1;
      csi_done <= 1'b0;
    end else begin
      csi_done <= 1'b0;
      if (!clocked_mode_enable) begin
        csi_busy <= 1'b0;
      end else if (!csi_busy) begin
        if (wr_tx) begin
          csi_busy <= 1'b1;
          csi_sh <= wr_data_i;
          csi_cnt <= 4'h0;
        end
      end else begin
        if (fall_ev) begin
          csi_out <= first_bit_select ? csi_sh[0] : csi_sh[7];
        end
        if (rise_ev) begin
          csi_sh <= first_bit_select ? {si_s, csi_sh[7:1]} : {csi_sh[6:0], si_s};
          csi_cnt <= csi_cnt + 4'h1;
          if (csi_cnt + 4'h1 == dmsp_pkg::BITS_8) begin
            csi_busy <= 1'b0;
            csi_done <= 1'b1;
          end
        end
      end
    end
  end

  // Serial clock output idles high and toggles only during internal transfers.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      serial_clock_pin_o <= 1'b1;
      serial_clock_pin_oe_o <= 1'b0;
    end else begin
      serial_clock_pin_oe_o <= clocked_mode_enable && clock_source_select;
      if (csi_busy && clock_source_select && tick) begin
        serial_clock_pin_o <= ~serial_clock_pin_o;
      end else if (!csi_busy) begin
        serial_clock_pin_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      serial_out_pin_o <= 1'b1;
      clocked_xfer_done_irq_o <= 1'b0;
    end else begin
      serial_out_pin_o <= clocked_mode_enable ? csi_out : tx_line;
      clocked_xfer_done_irq_o <= csi_done;
    end
  end

  // Receive buffer and error flags; a new load wins over a clearing read.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_buffer <= 8'h00;
      rx_full <= 1'b0;
      parity_err <= 1'b0;
      framing_err <= 1'b0;
      overrun_err <= 1'b0;
    end else begin
      if (rx_load) begin
        rx_buffer <= char_length_sel ? rx_sh : {1'b0, rx_sh[7:1]};
        rx_full <= 1'b1;
        parity_err <= rx_par_bad;
        framing_err <= !si_s;
        overrun_err <= rx_full && !rd_rx;
      end else if (csi_done) begin
        rx_buffer <= csi_sh;
        rx_full <= 1'b1;
      end else if (rd_rx) begin
        rx_full <= 1'b0;
        parity_err <= 1'b0;
        framing_err <= 1'b0;
        overrun_err <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        dmsp_pkg::ADDR_ASYNC: rd_data_o <= async_mode_control;
        dmsp_pkg::ADDR_CLOCKED: rd_data_o <= clocked_mode_control;
        dmsp_pkg::ADDR_BAUD: rd_data_o <= baud_source_select;
        dmsp_pkg::ADDR_TXSHIFT: rd_data_o <= tx_shift_reg;
        dmsp_pkg::ADDR_RXBUF: rd_data_o <= rx_buffer;
        dmsp_pkg::ADDR_STATUS: rd_data_o <= {2'h0, overrun_err, framing_err, parity_err,
                                              csi_busy, !rx_state[0], !tx_state[0]};
        default: rd_data_o <= 8'h00;
      endcase
    end else begin
      rd_data_o <= 8'h00;
    end
  end
endmodule : dmsp_top
`default_nettype wire

/* File: hdl/dmsp_pkg.sv */
// Constants and types shared by the dual mode serial port.
`default_nettype none
package dmsp_pkg;
  localparam logic [15:0] ADDR_ASYNC = 16'hff70;
  localparam logic [15:0] ADDR_CLOCKED = 16'hff72;
  localparam logic [15:0] ADDR_BAUD = 16'hff73;
  localparam logic [15:0] ADDR_TXSHIFT = 16'hff74;
  localparam logic [15:0] ADDR_RXBUF = 16'hff75;
  localparam logic [15:0] ADDR_STATUS = 16'hff76;
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam logic [7:0] ASYNC_MASK = 8'hfc;
  localparam logic [7:0] CLOCKED_MASK = 8'h86;
  localparam logic [7:0] BAUD_MASK = 8'hf0;
  localparam int TXE_BIT = 7;
  localparam int RXE_BIT = 6;
  localparam int PS_HI_BIT = 5;
  localparam int PS_LO_BIT = 4;
  localparam int CL_BIT = 3;
  localparam int SL_BIT = 2;
  localparam int CSIE_BIT = 7;
  localparam int DIR_BIT = 2;
  localparam int CSCK_BIT = 1;
  localparam int DIV_LSB = 4;
  localparam logic [2:0] SUB_LAST = 3'h7;
  localparam logic [2:0] SUB_HALF = 3'h3;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_7 = 4'h7;
  localparam logic [3:0] DIV_MAX = 4'h7;
  typedef enum logic [1:0] {
    DMSP_PAR_NONE = 2'h0,
    DMSP_PAR_ZERO = 2'h1,
    DMSP_PAR_ODD = 2'h2,
    DMSP_PAR_EVEN = 2'h3
  } dmsp_parity_t;
  typedef enum logic [4:0] {
    DMSP_IDLE = 5'h01,
    DMSP_START = 5'h02,
    DMSP_DATA = 5'h04,
    DMSP_PARITY = 5'h08,
    DMSP_STOP = 5'h10
  } dmsp_state_t;
endpackage : dmsp_pkg
`default_nettype wire

/* File: hdl/dmsp_baud_gen.sv */
// Source clock prescaler producing one tick per fx/2^(n+1) period.
`default_nettype none
module dmsp_baud_gen (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] div_code_i,
  output logic tick_o
);
  logic [7:0] count;

  // Codes above the last legal one are clamped so the generator never stalls.
  function automatic logic [7:0] div_mask(input logic [3:0] code);
    logic [3:0] n;
    n = (code > dmsp_pkg::DIV_MAX) ? dmsp_pkg::DIV_MAX : code;
    div_mask = 8'((9'h002 << n) - 9'h001);
  endfunction : div_mask

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count <= 8'h00;
    end else begin
      count <= count + 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= ((count & div_mask(div_code_i)) == div_mask(div_code_i));
    end
  end
endmodule : dmsp_baud_gen
`default_nettype wire

/* File: verification/dmsp_top_checker.sv */
// Concurrent checks on the ports of the dual mode serial port.
`default_nettype none
module dmsp_top_checker (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rd_data_o,
  input wire logic serial_clock_pin_oe_o,
  input wire logic serial_out_pin_o,
  input wire logic rx_complete_irq_o,
  input wire logic clocked_xfer_done_irq_o
);
  logic [7:0] asy;
  logic [7:0] csi;
  logic [7:0] baud;
  logic rx_en;
  logic csi_en;
  logic int_drv;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Shadow copies of the control registers, masked as the design stores them.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      asy <= 8'h00;
      csi <= 8'h00;
      baud <= 8'h00;
    end else if (wr_i) begin
      if (addr_i == dmsp_pkg::ADDR_ASYNC) asy <= wr_data_i & dmsp_pkg::ASYNC_MASK;
      if (addr_i == dmsp_pkg::ADDR_CLOCKED) csi <= wr_data_i & dmsp_pkg::CLOCKED_MASK;
      if (addr_i == dmsp_pkg::ADDR_BAUD) baud <= wr_data_i & dmsp_pkg::BAUD_MASK;
    end
  end
  assign rx_en = asy[dmsp_pkg::RXE_BIT];
  assign csi_en = csi[dmsp_pkg::CSIE_BIT];
  assign int_drv = csi_en && csi[dmsp_pkg::CSCK_BIT];
  rd_quiet_a: assert property (!rd_i |=> rd_data_o == 8'h00)
    else $error("read data not zero outside a read");
  async_read_a: assert property (rd_i && addr_i == dmsp_pkg::ADDR_ASYNC |=> rd_data_o == asy)
    else $error("async control read back wrong");
  csi_read_a: assert property (rd_i && addr_i == dmsp_pkg::ADDR_CLOCKED |=> rd_data_o == csi)
    else $error("clocked control read back wrong");
  baud_read_a: assert property (rd_i && addr_i == dmsp_pkg::ADDR_BAUD |=> rd_data_o == baud)
    else $error("baud select read back wrong");
  rx_irq_gate_a: assert property (rx_complete_irq_o |-> rx_en || $past(rx_en))
    else $error("reception pulse with receive disabled");
  rx_irq_pulse_a: assert property (rx_complete_irq_o |=> !rx_complete_irq_o)
    else $error("reception pulse longer than one cycle");
  xfer_gate_a: assert property (clocked_xfer_done_irq_o |-> csi_en || $past(csi_en))
    else $error("transfer done pulse with clocked mode off");
  oe_drive_a: assert property (serial_clock_pin_oe_o |-> int_drv || $past(int_drv))
    else $error("clock pin driven without internal clock");
  oe_follow_a: assert property (int_drv [*2] |-> serial_clock_pin_oe_o)
    else $error("clock pin not driven with internal clock");
  line_idle_a: assert property ((!asy[dmsp_pkg::TXE_BIT] && !csi_en) [*3] |-> serial_out_pin_o)
    else $error("serial out not idle high");
endmodule : dmsp_top_checker
bind dmsp_top dmsp_top_checker dmsp_top_checker_i (.clk_i, .reset_n_i, .addr_i, .wr_data_i, .wr_i, .rd_i,
  .rd_data_o, .serial_clock_pin_oe_o, .serial_out_pin_o, .rx_complete_irq_o, .clocked_xfer_done_irq_o);
`default_nettype wire

/* File: verification/dmsp_peer.sv */
// Far-side model: an asynchronous sender and a clocked serial peripheral.
`default_nettype none
module dmsp_peer (
  input wire logic clk_i,
  input wire logic sck_i,
  input wire logic so_i,
  output logic si_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] slave_tx;
  logic [7:0] slave_rx;
  logic lsb_first;
  logic clocked;
  int n_rise;
  initial begin
    si_o = 1'b1;
    slave_tx = 8'h00;
    slave_rx = 8'h00;
    lsb_first = 1'b0;
    clocked = 1'b0;
    n_rise = 0;
  end
  // Sends bits from bit 0 upward, each held for bit_clks cycles, then leaves the line idle high.
  task automatic send_frame(input logic [11:0] bits, input int n, input int bit_clks);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      si_o <= bits[i];
      repeat (bit_clks - 1) @(posedge clk_i);
    end
    @(posedge clk_i);
    si_o <= 1'b1;
  endtask : send_frame
  always @(negedge sck_i) begin
    if (clocked) si_o <= lsb_first ? slave_tx[n_rise] : slave_tx[7 - n_rise];
  end
  // A released data line returns to idle high.
  always @(negedge clocked) si_o <= 1'b1;
  always @(posedge sck_i) begin
    if (clocked) begin
      slave_rx <= lsb_first ? {so_i, slave_rx[7:1]} : {slave_rx[6:0], so_i};
      n_rise <= n_rise + 1;
    end
  end
endmodule : dmsp_peer
`default_nettype wire

/* File: verification/dmsp_top_tb.sv */
// Self-checking testbench of the dual mode serial port.
`default_nettype none
module dmsp_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i;
  logic reset_n_i;
  logic [15:0] addr_i;
  logic [7:0] wr_data_i;
  logic wr_i;
  logic rd_i;
  logic [7:0] rd_data_o;
  logic sck_o, sck_oe, ext_sck, sck, so, si, rx_irq, tx_irq, cx_irq;
  logic [7:0] d;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  int n_rx = 0;
  assign sck = sck_oe ? sck_o : ext_sck;
  dmsp_top dmsp_top_i (.clk_i, .reset_n_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o,
    .serial_clock_pin_i(sck), .serial_clock_pin_o(sck_o), .serial_clock_pin_oe_o(sck_oe),
    .serial_in_pin_i(si), .serial_out_pin_o(so), .rx_complete_irq_o(rx_irq),
    .tx_complete_irq_o(tx_irq), .clocked_xfer_done_irq_o(cx_irq));
  dmsp_peer dmsp_peer_i (.clk_i, .sck_i(sck), .so_i(so), .si_o(si));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict
  always @(posedge clk_i) begin
    cyc++;
    if (rx_irq) n_rx++;
    if (cyc == 40000) begin
      $display("ERROR %0t: run did not finish", $time);
      miscompares++;
      print_verdict();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: byte %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: bit %b expected %b", $time, got, exp);
    end
  endtask : chk1
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wr_data_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(posedge clk_i);
    v = rd_data_o;
  endtask : rd
  task automatic t_regs();
    logic [15:0] a [4] = '{dmsp_pkg::ADDR_ASYNC, dmsp_pkg::ADDR_CLOCKED, dmsp_pkg::ADDR_BAUD, 16'hff71};
    logic [7:0] v [4] = '{8'hff, 8'hff, 8'h7f, 8'hff};
    logic [7:0] m [4] = '{dmsp_pkg::ASYNC_MASK, dmsp_pkg::CLOCKED_MASK, dmsp_pkg::BAUD_MASK, 8'h00};
    for (int i = 0; i < 4; i++) begin
      rd(a[i], d);
      chk(d, dmsp_pkg::RESET_VAL);
      wr(a[i], v[i]);
      rd(a[i], d);
      chk(d, v[i] & m[i]);
      wr(a[i], 8'h00);
    end
  endtask : t_regs
  // One transmitted frame at a bit time of 16 cycles; p also picks length and stop count.
  task automatic t_tx(input logic [1:0] p);
    logic [7:0] v = 8'hb4;
    int nb = p[0] ? 8 : 7;
    logic par = ^(p[0] ? v : {1'b0, v[6:0]});
    int k;
    wr(dmsp_pkg::ADDR_ASYNC, {2'b10, p, p[0], p[1], 2'b00});
    wr(dmsp_pkg::ADDR_TXSHIFT, v);
    for (k = 0; k < 64 && so; k++) @(posedge clk_i);
    repeat (8) @(posedge clk_i);
    chk1(so, 1'b0);
    for (int i = 0; i < nb; i++) begin
      repeat (16) @(posedge clk_i);
      chk1(so, v[i]);
    end
    if (p != 2'h0) begin
      repeat (16) @(posedge clk_i);
      chk1(so, p == 2'h1 ? 1'b0 : (p == 2'h2 ? ~par : par));
    end
    for (int i = 0; i <= int'(p[1]); i++) begin
      repeat (16) @(posedge clk_i);
      chk1(so, 1'b1);
    end
    for (k = 0; k < 40 && !tx_irq; k++) @(posedge clk_i);
    chk1(tx_irq, 1'b1);
  endtask : t_tx
  // Transmit aborted mid-frame by clearing the enable, then the shift register is written again with transmit still disabled.
  task automatic t_abort();
    wr(dmsp_pkg::ADDR_ASYNC, 8'h88);
    wr(dmsp_pkg::ADDR_TXSHIFT, 8'h00);
    repeat (40) @(posedge clk_i);
    chk1(so, 1'b0);
    wr(dmsp_pkg::ADDR_ASYNC, 8'h08);
    repeat (3) @(posedge clk_i);
    chk1(so, 1'b1);
    wr(dmsp_pkg::ADDR_TXSHIFT, 8'hff);
  endtask : t_abort
  // Receive disabled early (0), between buffer load and pulse (1), or after the pulse (2).
  task automatic t_rx(input int mode, input logic [7:0] v, input logic [7:0] prev);
    int n0;
    int k;
    wr(dmsp_pkg::ADDR_BAUD, 8'h30);
    wr(dmsp_pkg::ADDR_ASYNC, 8'h48);
    n0 = n_rx;
    d = prev;
    fork
      dmsp_peer_i.send_frame({3'b111, v, 1'b0}, 10, 128);
      begin
        if (mode == 0) repeat (600) @(posedge clk_i);
        else if (mode == 1) for (k = 0; k < 900 && d !== v; k++) rd(dmsp_pkg::ADDR_RXBUF, d);
        else begin
          for (k = 0; k < 2000 && n_rx == n0; k++) @(posedge clk_i);
          wr(dmsp_pkg::ADDR_CLOCKED, 8'h04);
        end
        wr(dmsp_pkg::ADDR_ASYNC, 8'h00);
      end
    join
    repeat (200) @(posedge clk_i);
    chk1(n_rx != n0, mode == 2);
    rd(dmsp_pkg::ADDR_RXBUF, d);
    chk(d, mode == 0 ? prev : v);
  endtask : t_rx
  task automatic csi_arm(input logic [7:0] slave, input logic lsb);
    dmsp_peer_i.slave_tx = slave;
    dmsp_peer_i.lsb_first = lsb;
    dmsp_peer_i.n_rise = 0;
    dmsp_peer_i.clocked = 1'b1;
  endtask : csi_arm
  task automatic csi_end(input logic [7:0] slave, input logic [7:0] sent);
    int k;
    for (k = 0; k < 400 && !cx_irq; k++) @(posedge clk_i);
    chk1(cx_irq, 1'b1);
    rd(dmsp_pkg::ADDR_RXBUF, d);
    chk(d, slave);
    chk(dmsp_peer_i.slave_rx, sent);
    wr(dmsp_pkg::ADDR_CLOCKED, 8'h00);
    dmsp_peer_i.clocked = 1'b0;
  endtask : csi_end
  task automatic t_csi(input logic lsb, input logic [3:0] code);
    int k;
    wr(dmsp_pkg::ADDR_BAUD, {code, 4'h0});
    csi_arm(8'h96, lsb);
    wr(dmsp_pkg::ADDR_TXSHIFT, 8'h3c);
    wr(dmsp_pkg::ADDR_CLOCKED, {5'h10, lsb, 2'b10});
    for (k = 0; k < 40 && sck; k++) @(posedge clk_i);
    chk1(sck, 1'b1);
    chk1(sck_oe, 1'b1);
    wr(dmsp_pkg::ADDR_TXSHIFT, 8'h3c);
    for (k = 0; k < 99 && sck; k++) @(posedge clk_i);
    for (k = 0; k < 99 && !sck; k++) @(posedge clk_i);
    for (; k < 99 && sck; k++) @(posedge clk_i);
    chk(8'(k), 8'(4 << code));
    csi_end(8'h96, 8'h3c);
  endtask : t_csi
  task automatic t_ext();
    csi_arm(8'h5a, 1'b0);
    wr(dmsp_pkg::ADDR_CLOCKED, 8'h80);
    wr(dmsp_pkg::ADDR_TXSHIFT, 8'hc3);
    chk1(sck_oe, 1'b0);
    for (int k = 0; k < 16; k++) begin
      repeat (10) @(posedge clk_i);
      ext_sck <= k[0];
    end
    csi_end(8'h5a, 8'hc3);
  endtask : t_ext
  initial begin
    reset_n_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 16'h0000;
    wr_data_i = 8'h00;
    ext_sck = 1'b1;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_regs();
    t_abort();
    for (int p = 0; p < 4; p++) t_tx(2'(p));
    wr(dmsp_pkg::ADDR_ASYNC, 8'h00);
    t_rx(0, 8'h3c, 8'h00);
    t_rx(1, 8'ha5, 8'h00);
    t_rx(2, 8'h5a, 8'ha5);
    t_csi(1'b0, 4'h0);
    t_csi(1'b1, 4'h1);
    t_ext();
    print_verdict();
  end
endmodule : dmsp_top_tb
`default_nettype wire
